/* File: rtl/rfa_core.sv */
// register file with single cycle alu, status register and pointer pairs
`timescale 1ns/1ps
`default_nettype none
module rfa_core
   import rfa_pkg::*;
(
   // clock and reset
   input  wire logic          I_CLK,
   input  wire logic          I_RST_N,
   // command from decoder
   input  wire rfa_cmd_t      I_CMD,
   // direct register read port
   input  wire logic [4:0]    I_RD_IDX,
   output logic [7:0]         O_RD_DATA,
   // status and pointers
   output logic [7:0]         O_STATUS,
   output var rfa_ptrs_t      O_PTRS,
   output logic [15:0]        O_TABLE_ADDR,
   output logic               O_DONE
);

   // ****************************************
   // reset release
   // ****************************************
   logic       rst_s1_q;
   logic       rst_n_q;

   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // ****************************************
   // register file
   // ****************************************
   logic [7:0]   regs_q [NUM_REGS];
   logic [7:0]   sreg_q;
   logic         done_q;
   logic [7:0]   op_a;
   logic [7:0]   op_a_hi;
   logic [7:0]   op_b;
   logic [4:0]   dst_hi;
   rfa_alu_res_t alu_res;

   function automatic logic [4:0] pair_lo(input logic [4:0] idx);
      pair_lo = {idx[4:1], 1'b0};
   endfunction : pair_lo

   assign dst_hi  = pair_lo(I_CMD.dst) + 5'h01;
   assign op_a    = regs_q[I_CMD.dst];
   assign op_a_hi = regs_q[dst_hi];
   assign op_b    = I_CMD.use_imm ? I_CMD.imm : regs_q[I_CMD.src];

   rfa_alu u_alu (
      .i_op     (I_CMD.op),
      .i_a      (I_CMD.op inside {OP_ADIW, OP_SBIW} ? regs_q[pair_lo(I_CMD.dst)] : op_a),
      .i_a_hi   (op_a_hi),
      .i_b      (op_b),
      .i_bitsel (I_CMD.bitsel),
      .i_sreg   (sreg_q),
      .o_res    (alu_res)
   );

   genvar gi;
   generate
      for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
         always_ff @(posedge I_CLK or negedge rst_n_q) begin
            if (!rst_n_q) begin
               regs_q[gi] <= REG_RST;
            end else if (I_CMD.valid && alu_res.write) begin
               if (alu_res.wide) begin
                  if (I_CMD.op inside {OP_ADIW, OP_SBIW}) begin
                     if (5'(gi) == pair_lo(I_CMD.dst)) begin
                        regs_q[gi] <= alu_res.res[7:0];
                     end else if (5'(gi) == dst_hi) begin
                        regs_q[gi] <= alu_res.res[15:8];
                     end
                  end else if (gi == 0) begin
                     regs_q[gi] <= alu_res.res[7:0];
                  end else if (gi == 1) begin
                     regs_q[gi] <= alu_res.res[15:8];
                  end
               end else if (5'(gi) == I_CMD.dst) begin
                  regs_q[gi] <= alu_res.res[7:0];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // status register
   // ****************************************
   always_ff @(posedge I_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         sreg_q <= STATUS_RST;
      end else if (I_CMD.valid) begin
         sreg_q <= (sreg_q & ~alu_res.fmask) | (alu_res.flags & alu_res.fmask);
      end
   end

   always_ff @(posedge I_CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         done_q <= 1'b0;
      end else begin
         done_q <= I_CMD.valid;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign O_RD_DATA    = regs_q[I_RD_IDX];
   assign O_STATUS     = sreg_q;
   assign O_PTRS       = '{x: {regs_q[PTR_X_LO + 5'h01], regs_q[PTR_X_LO]},
                           y: {regs_q[PTR_Y_LO + 5'h01], regs_q[PTR_Y_LO]},
                           z: {regs_q[PTR_Z_LO + 5'h01], regs_q[PTR_Z_LO]}};
   assign O_TABLE_ADDR = O_PTRS.z;
   assign O_DONE       = done_q;

   // ****************************************
   // assertions
   // ****************************************
   a_add_writeback: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_ADD && !I_CMD.use_imm && I_CMD.dst != I_CMD.src)
      |=> regs_q[$past(I_CMD.dst)] == 8'($past(op_a) + $past(op_b)))
      else $error("add result not written back");
   a_imm_writeback: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_MOV && I_CMD.use_imm)
      |=> regs_q[$past(I_CMD.dst)] == $past(I_CMD.imm))
      else $error("immediate move lost");
   a_zero_flag: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_XOR && !I_CMD.use_imm && I_CMD.dst == I_CMD.src)
      |=> sreg_q[SB_Z] && regs_q[$past(I_CMD.dst)] == 8'h00)
      else $error("zero flag not set");
   a_carry_add: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_ADD)
      |=> sreg_q[SB_C] == ($past({1'b0, op_a} + {1'b0, op_b}) > 9'h0ff))
      else $error("carry flag wrong");
   a_cmp_nowrite: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_CMP) |=> regs_q[$past(I_CMD.dst)] == $past(op_a))
      else $error("compare wrote a register");
   a_mul_product: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_MUL)
      |=> {regs_q[1], regs_q[0]} == 16'($past(op_a) * $past(op_b)))
      else $error("unsigned product wrong");
   a_ptr_adjust: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_ADIW && pair_lo(I_CMD.dst) == PTR_Z_LO)
      |=> O_TABLE_ADDR == 16'($past(O_PTRS.z) + {10'h000, $past(I_CMD.imm[5:0])}))
      else $error("pointer adjust wrong");
   a_sign_flag: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      $past(I_CMD.valid) && $past(alu_res.fmask[SB_S])
      |-> sreg_q[SB_S] == (sreg_q[SB_N] ^ sreg_q[SB_V]))
      else $error("sign flag inconsistent");
   a_done_pulse: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      I_CMD.valid |=> O_DONE)
      else $error("done missing");
   a_chain_zero: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op inside {OP_SBC, OP_CPC} && !sreg_q[SB_Z]) |=> !sreg_q[SB_Z])
      else $error("chained zero flag set");
   a_nop_hold: assert property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_NOP) |=> $stable(sreg_q))
      else $error("no-op changed status");
   c_add: cover property (@(posedge I_CLK) disable iff (!rst_n_q)
      I_CMD.valid && I_CMD.op == OP_ADD);
   c_adc_chain: cover property (@(posedge I_CLK) disable iff (!rst_n_q)
      (I_CMD.valid && I_CMD.op == OP_ADD) ##1 (I_CMD.valid && I_CMD.op == OP_ADC));
   c_fmuls: cover property (@(posedge I_CLK) disable iff (!rst_n_q)
      I_CMD.valid && I_CMD.op == OP_FMULS);
   c_sbiw: cover property (@(posedge I_CLK) disable iff (!rst_n_q)
      I_CMD.valid && I_CMD.op == OP_SBIW);

endmodule : rfa_core
`default_nettype wire

/* File: rtl/rfa_pkg.sv */
// package of constants and types for the register file and alu datapath
package rfa_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_REGS   = 32;
   localparam int DATA_W     = 8;
   localparam int IDX_W      = 5;
   localparam int PTR_W      = 16;

   // ****************************************
   // pointer pairs: low byte register index
   // ****************************************
   localparam logic [4:0] PTR_X_LO = 5'h1a;
   localparam logic [4:0] PTR_Y_LO = 5'h1c;
   localparam logic [4:0] PTR_Z_LO = 5'h1e;

   // ****************************************
   // status field positions
   // ****************************************
   localparam int SB_C = 0;
   localparam int SB_Z = 1;
   localparam int SB_N = 2;
   localparam int SB_V = 3;
   localparam int SB_S = 4;
   localparam int SB_H = 5;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] REG_RST    = 8'h00;

   // ****************************************
   // operations
   // ****************************************
   typedef enum logic [4:0] {
      OP_ADD  = 5'h00,
      OP_ADC  = 5'h01,
      OP_SUB  = 5'h02,
      OP_SBC  = 5'h03,
      OP_AND  = 5'h04,
      OP_OR   = 5'h05,
      OP_XOR  = 5'h06,
      OP_MOV  = 5'h07,
      OP_COM  = 5'h08,
      OP_NEG  = 5'h09,
      OP_INC  = 5'h0a,
      OP_DEC  = 5'h0b,
      OP_LSR  = 5'h0c,
      OP_ROR  = 5'h0d,
      OP_ASR  = 5'h0e,
      OP_SWAP = 5'h0f,
      OP_BSET = 5'h10,
      OP_BCLR = 5'h11,
      OP_CMP  = 5'h12,
      OP_CPC  = 5'h13,
      OP_ADIW = 5'h14,
      OP_SBIW = 5'h15,
      OP_MUL  = 5'h16,
      OP_MULS = 5'h17,
      OP_MULSU= 5'h18,
      OP_FMUL = 5'h19,
      OP_FMULS= 5'h1a,
      OP_FMULSU=5'h1b,
      OP_NOP  = 5'h1f
   } rfa_op_t;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic            valid;
      rfa_op_t         op;
      logic [4:0]      dst;
      logic [4:0]      src;
      logic            use_imm;
      logic [7:0]      imm;
      logic [2:0]      bitsel;
   } rfa_cmd_t;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } rfa_ptrs_t;

   typedef struct packed {
      logic [15:0] res;
      logic        wide;
      logic        write;
      logic [7:0]  flags;
      logic [7:0]  fmask;
   } rfa_alu_res_t;

endpackage : rfa_pkg

/* File: rtl/rfa_alu.sv */
// combinational alu with arithmetic, logic, bit and multiply operations
`timescale 1ns/1ps
`default_nettype none
module rfa_alu
   import rfa_pkg::*;
(
   // operands
   input  wire rfa_op_t      i_op,
   input  wire logic [7:0]   i_a,
   input  wire logic [7:0]   i_a_hi,
   input  wire logic [7:0]   i_b,
   input  wire logic [2:0]   i_bitsel,
   input  wire logic [7:0]   i_sreg,
   // result
   output var rfa_alu_res_t   o_res
);

   logic [8:0]  sum9;
   logic [4:0]  half5;
   logic [15:0] prod;
   logic [16:0] w17;
   logic        cin;
   logic        is_sub;
   logic [7:0]  bop;
   logic        c_o;
   logic        v_o;
   logic [7:0]  r8;

   // ****************************************
   // operation evaluation
   // ****************************************
   always_comb begin
      cin    = i_sreg[SB_C];
      is_sub = (i_op == OP_SUB) || (i_op == OP_SBC) || (i_op == OP_CMP) || (i_op == OP_CPC);
      bop    = i_b;
      sum9   = 9'h000;
      half5  = 5'h00;
      prod   = 16'h0000;
      w17    = 17'h00000;
      c_o    = 1'b0;
      v_o    = 1'b0;
      r8     = 8'h00;
      o_res  = '0;
      o_res.write = 1'b1;
      o_res.fmask = 8'h3f;
      unique case (i_op)
         OP_ADD, OP_ADC: begin
            sum9  = {1'b0, i_a} + {1'b0, bop} + {8'h00, (i_op == OP_ADC) & cin};
            half5 = {1'b0, i_a[3:0]} + {1'b0, bop[3:0]} + {4'h0, (i_op == OP_ADC) & cin};
            r8    = sum9[7:0];
            c_o   = sum9[8];
            v_o   = (i_a[7] == bop[7]) && (r8[7] != i_a[7]);
         end
         OP_SUB, OP_SBC, OP_CMP, OP_CPC: begin
            sum9  = {1'b0, i_a} - {1'b0, bop}
                  - {8'h00, ((i_op == OP_SBC) || (i_op == OP_CPC)) & cin};
            half5 = {1'b0, i_a[3:0]} - {1'b0, bop[3:0]}
                  - {4'h0, ((i_op == OP_SBC) || (i_op == OP_CPC)) & cin};
            r8    = sum9[7:0];
            c_o   = sum9[8];
            v_o   = (i_a[7] != bop[7]) && (r8[7] != i_a[7]);
            o_res.write = (i_op == OP_SUB) || (i_op == OP_SBC);
         end
         OP_AND:  r8 = i_a & bop;
         OP_OR:   r8 = i_a | bop;
         OP_XOR:  r8 = i_a ^ bop;
         OP_MOV: begin
            r8 = bop;
            o_res.fmask = 8'h00;
         end
         OP_COM: begin
            r8  = ~i_a;
            c_o = 1'b1;
         end
         OP_NEG: begin
            sum9  = 9'h000 - {1'b0, i_a};
            half5 = 5'h00 - {1'b0, i_a[3:0]};
            r8    = sum9[7:0];
            c_o   = (i_a != 8'h00);
            v_o   = (i_a == 8'h80);
         end
         OP_INC: begin
            r8  = i_a + 8'h01;
            v_o = (i_a == 8'h7f);
            c_o = i_sreg[SB_C];
         end
         OP_DEC: begin
            r8  = i_a - 8'h01;
            v_o = (i_a == 8'h80);
            c_o = i_sreg[SB_C];
         end
         OP_LSR, OP_ROR, OP_ASR: begin
            r8  = {(i_op == OP_ROR) ? cin : ((i_op == OP_ASR) ? i_a[7] : 1'b0), i_a[7:1]};
            c_o = i_a[0];
            v_o = r8[7] ^ i_a[0];
         end
         OP_SWAP: begin
            r8 = {i_a[3:0], i_a[7:4]};
            o_res.fmask = 8'h00;
         end
         OP_BSET, OP_BCLR: begin
            r8 = i_a;
            r8[i_bitsel] = (i_op == OP_BSET);
            o_res.fmask = 8'h00;
         end
         OP_ADIW, OP_SBIW: begin
            w17 = (i_op == OP_ADIW) ? ({1'b0, i_a_hi, i_a} + {11'h000, bop[5:0]})
                                    : ({1'b0, i_a_hi, i_a} - {11'h000, bop[5:0]});
            o_res.res  = w17[15:0];
            o_res.wide = 1'b1;
            c_o = w17[16];
            v_o = (i_op == OP_ADIW) ? (~i_a_hi[7] & w17[15]) : (i_a_hi[7] & ~w17[15]);
            o_res.fmask = 8'h1f;
         end
         OP_MUL, OP_MULS, OP_MULSU, OP_FMUL, OP_FMULS, OP_FMULSU: begin
            unique case (i_op)
               OP_MULS, OP_FMULS:   prod = 16'($signed(i_a) * $signed(i_b));
               OP_MULSU, OP_FMULSU: prod = 16'($signed({i_a[7], i_a}) * $signed({1'b0, i_b}));
               default:             prod = i_a * i_b;
            endcase
            c_o = prod[15];
            if ((i_op == OP_FMUL) || (i_op == OP_FMULS) || (i_op == OP_FMULSU)) begin
               prod = {prod[14:0], 1'b0};
            end
            o_res.res  = prod;
            o_res.wide = 1'b1;
            o_res.fmask = 8'h03;
         end
         default: begin
            o_res.write = 1'b0;
            o_res.fmask = 8'h00;
         end
      endcase
      if (!o_res.wide) begin
         o_res.res = {8'h00, r8};
      end
      // flag values
      o_res.flags[SB_C] = c_o;
      o_res.flags[SB_Z] = o_res.wide ? (o_res.res == 16'h0000) : (r8 == 8'h00);
      if (is_sub && ((i_op == OP_SBC) || (i_op == OP_CPC))) begin
         o_res.flags[SB_Z] = (r8 == 8'h00) & i_sreg[SB_Z];
      end
      o_res.flags[SB_N] = o_res.wide ? o_res.res[15] : r8[7];
      o_res.flags[SB_V] = v_o;
      o_res.flags[SB_S] = o_res.flags[SB_N] ^ v_o;
      o_res.flags[SB_H] = half5[4];
      if ((i_op == OP_INC) || (i_op == OP_DEC)) begin
         o_res.fmask = 8'h1e;
      end
      if ((i_op >= OP_AND) && (i_op <= OP_XOR)) begin
         o_res.fmask = 8'h1e;
      end
   end

endmodule : rfa_alu
`default_nettype wire

/* File: testbench/rfa_dec_model.sv */
// decoder model that registers bench requests into datapath commands
`timescale 1ns/1ps
`default_nettype none
module rfa_dec_model
   import rfa_pkg::*;
(
   // clock and reset
   input  wire logic     i_clk,
   input  wire logic     i_rst_n,
   // request from bench
   input  wire rfa_cmd_t i_req,
   // command to datapath
   output var rfa_cmd_t  o_cmd
);
   // ****************************************
   // one command per cycle, idle in reset
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cmd <= '0;
      end else begin
         o_cmd <= i_req;
      end
   end
endmodule : rfa_dec_model
`default_nettype wire

/* File: testbench/cpu_register_file_alu_tb.sv */
// self-checking bench for the register file and alu datapath
`timescale 1ns/1ps
`default_nettype none
module cpu_register_file_alu_tb
   import rfa_pkg::*;
;
   logic       clk;
   logic       rst_n;
   rfa_cmd_t   req;
   rfa_cmd_t   cmd;
   logic [4:0] rd_idx;
   logic [7:0] rd_data;
   logic [7:0] status;
   rfa_ptrs_t  ptrs;
   logic [15:0] tbl;
   logic       done;
   int         n_mismatch;
   int         n_checks;
   int         cyc;

   rfa_dec_model dec (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_cmd(cmd));

   rfa_core uut (
      .I_CLK(clk), .I_RST_N(rst_n), .I_CMD(cmd), .I_RD_IDX(rd_idx),
      .O_RD_DATA(rd_data), .O_STATUS(status), .O_PTRS(ptrs),
      .O_TABLE_ADDR(tbl), .O_DONE(done)
   );

   // ****************************************
   // clock and timeout
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic end_sim();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic ex(input rfa_op_t op, input logic [4:0] d, input logic [4:0] s,
                     input logic u, input logic [7:0] im, input logic [2:0] bs);
      @(posedge clk);
      req <= '{1'b1, op, d, s, u, im, bs};
      @(posedge clk);
      req.valid <= 1'b0;
      @(posedge clk);
      #1 chk(done, 1);
   endtask : ex

   task automatic exr(input rfa_op_t op, input logic [4:0] d, input logic [4:0] s);
      ex(op, d, s, 1'b0, 8'h00, 3'h0);
   endtask : exr

   task automatic exi(input rfa_op_t op, input logic [4:0] d, input logic [7:0] im);
      ex(op, d, 5'h00, 1'b1, im, 3'h0);
   endtask : exi

   task automatic st(input logic [4:0] r, input logic [7:0] v);
      exi(OP_AND, r, 8'h00);
      exi(OP_OR, r, v);
   endtask : st

   task automatic rd(input logic [4:0] r, input logic [7:0] e);
      @(posedge clk);
      rd_idx <= r;
      #1 chk(rd_data, e);
   endtask : rd

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      for (int i = 0; i < 32; i++) rd(5'(i), 8'h00);
      chk(status, 8'h00);
   endtask : t_reset

   task automatic t_all_regs();
      for (int i = 0; i < 32; i++) st(5'(i), 8'(i * 7 + 3));
      for (int i = 0; i < 32; i++) rd(5'(i), 8'(i * 7 + 3));
   endtask : t_all_regs

   task automatic t_arith();
      st(5'd3, 8'h7f);
      st(5'd4, 8'h01);
      exr(OP_ADD, 5'd3, 5'd4);
      chk(status, 8'h2c);
      rd(5'd3, 8'h80);
      st(5'd16, 8'hff);
      st(5'd17, 8'h01);
      st(5'd18, 8'h00);
      exi(OP_ADD, 5'd16, 8'h01);
      chk(status, 8'h23);
      exr(OP_ADC, 5'd17, 5'd18);
      chk(status, 8'h00);
      rd(5'd17, 8'h02);
      st(5'd20, 8'h10);
      exi(OP_SUB, 5'd20, 8'h01);
      chk(status, 8'h20);
      rd(5'd20, 8'h0f);
   endtask : t_arith

   task automatic t_logic_single();
      exi(OP_XOR, 5'd20, 8'h8f);
      chk(status, 8'h34);
      rd(5'd20, 8'h80);
      exr(OP_COM, 5'd20, 5'd0);
      chk(status, 8'h01);
      exr(OP_INC, 5'd20, 5'd0);
      chk(status, 8'h0d);
      exr(OP_CMP, 5'd20, 5'd20);
      chk(status, 8'h02);
      rd(5'd20, 8'h80);
   endtask : t_logic_single

   task automatic t_ptrs();
      st(5'd26, 8'hff);
      st(5'd27, 8'h00);
      st(5'd28, 8'h34);
      st(5'd29, 8'h12);
      st(5'd30, 8'h00);
      st(5'd31, 8'h00);
      chk(ptrs.x, 16'h00ff);
      chk(ptrs.y, 16'h1234);
      exi(OP_ADIW, 5'd27, 8'h01);
      chk(ptrs.x, 16'h0100);
      exi(OP_SBIW, 5'd30, 8'h01);
      chk(ptrs.z, 16'hffff);
      chk(status & 8'h01, 8'h01);
      chk(tbl, 16'hffff);
      exi(OP_ADIW, 5'd31, 8'h02);
      chk(tbl, 16'h0001);
      chk(status & 8'h01, 8'h01);
   endtask : t_ptrs

   task automatic t_mul();
      st(5'd2, 8'hff);
      st(5'd3, 8'hff);
      exr(OP_MUL, 5'd2, 5'd3);
      chk(ptrs.x, 16'h0100);
      rd(5'd0, 8'h01);
      rd(5'd1, 8'hfe);
      chk(status & 8'h03, 8'h01);
      exr(OP_MULS, 5'd2, 5'd3);
      rd(5'd1, 8'h00);
      chk(status & 8'h03, 8'h00);
      exr(OP_MULSU, 5'd2, 5'd3);
      rd(5'd0, 8'h01);
      rd(5'd1, 8'hff);
      st(5'd4, 8'h40);
      st(5'd5, 8'h40);
      exr(OP_FMUL, 5'd4, 5'd5);
      rd(5'd0, 8'h00);
      rd(5'd1, 8'h20);
      chk(status & 8'h03, 8'h00);
   endtask : t_mul

   task automatic t_nop();
      logic [7:0] s;
      s = status;
      ex(OP_NOP, 5'd5, 5'd6, 1'b1, 8'hff, 3'h0);
      @(posedge clk);
      #1 chk(done, 0);
      chk(status, s);
      rd(5'd5, 8'h40);
   endtask : t_nop

   task automatic t_chain();
      st(5'd16, 8'hf0);
      st(5'd17, 8'h01);
      st(5'd18, 8'h20);
      st(5'd19, 8'h02);
      @(posedge clk);
      req <= '{1'b1, OP_ADD, 5'd16, 5'd18, 1'b0, 8'h00, 3'h0};
      @(posedge clk);
      req <= '{1'b1, OP_ADC, 5'd17, 5'd19, 1'b0, 8'h00, 3'h0};
      @(posedge clk);
      req.valid <= 1'b0;
      rd(5'd16, 8'h10);
      rd(5'd17, 8'h04);
      chk(status & 8'h01, 8'h00);
   endtask : t_chain

   task automatic t_ops();
      logic [7:0] s;
      st(5'd6, 8'h81);
      exr(OP_LSR, 5'd6, 5'd0);
      chk(status, 8'h19);
      exr(OP_ROR, 5'd6, 5'd0);
      rd(5'd6, 8'ha0);
      exr(OP_ASR, 5'd6, 5'd0);
      chk(status, 8'h0c);
      exr(OP_SWAP, 5'd6, 5'd0);
      rd(5'd6, 8'h0d);
      exr(OP_NEG, 5'd6, 5'd0);
      chk(status, 8'h35);
      exr(OP_DEC, 5'd6, 5'd0);
      ex(OP_BSET, 5'd6, 5'd0, 1'b0, 8'h00, 3'h0);
      ex(OP_BCLR, 5'd6, 5'd0, 1'b0, 8'h00, 3'h7);
      rd(5'd6, 8'h73);
      chk(status, 8'h35);
      exr(OP_MOV, 5'd7, 5'd6);
      exi(OP_MOV, 5'd8, 8'h5a);
      rd(5'd7, 8'h73);
      rd(5'd8, 8'h5a);
      exr(OP_XOR, 5'd8, 5'd8);
      chk(status, 8'h23);
      st(5'd9, 8'h05);
      exi(OP_SBC, 5'd9, 8'h04);
      chk(status, 8'h00);
      rd(5'd9, 8'h00);
      exr(OP_XOR, 5'd10, 5'd10);
      exi(OP_CPC, 5'd10, 8'h01);
      chk(status, 8'h35);
      rd(5'd10, 8'h00);
      st(5'd11, 8'hc0);
      st(5'd12, 8'h40);
      exr(OP_FMULS, 5'd11, 5'd12);
      rd(5'd1, 8'he0);
      exr(OP_FMULSU, 5'd11, 5'd11);
      rd(5'd1, 8'ha0);
      chk(status & 8'h03, 8'h01);
      s = status;
      ex(rfa_op_t'(5'h1c), 5'd12, 5'd12, 1'b1, 8'hff, 3'h0);
      chk(status, s);
      rd(5'd12, 8'h40);
   endtask : t_ops

   task automatic t_midreset();
      @(posedge clk);
      rst_n <= 1'b0;
      #1 chk(status, 8'h00);
      chk(tbl, 16'h0000);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
   endtask : t_midreset

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      rst_n = 1'b0;
      req = '0;
      rd_idx = 5'h00;
      n_mismatch = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_all_regs();
      t_arith();
      t_logic_single();
      t_ptrs();
      t_mul();
      t_nop();
      t_chain();
      t_ops();
      t_midreset();
      end_sim();
   end
endmodule : cpu_register_file_alu_tb
`default_nettype wire
